// ===== rtl/rmc_params.svh
// constants for the rendering mode block: offsets, field positions, widths
// assumes inclusion by bare name from every file of the block
// ==========================================
`ifndef RMC_PARAMS_SVH
`define RMC_PARAMS_SVH

// ==========================================
// register map
`define RMC_RENDERING_MODE_OFFSET 12'h000
`define RMC_APB_ADDR_W 12

// ==========================================
// rendering mode fields
`define RMC_MEMORY_WIDTH_BIT 6
`define RMC_PIXEL_DEPTH_BIT 0
`define RMC_REG_W 16

// ==========================================
// graphics memory addressing
`define RMC_BYTE_ADDR_W 23
`define RMC_X_W 10
`define RMC_Y_W 13
`define RMC_X_BITS_512 4'h9
`define RMC_X_BITS_1024 4'ha
`define RMC_X_LOW_W 3
`define RMC_Y_LOW_W 2

`endif

// ===== rtl/rmc_pkg.sv
// types shared by the rendering mode block
// assumes rmc_params.svh is on the include path
`default_nettype none
`include "rmc_params.svh"

package rmc_pkg;
  typedef logic [`RMC_REG_W-1:0] rmc_reg_t;
  typedef logic [`RMC_BYTE_ADDR_W-1:0] rmc_byte_addr_t;
  typedef enum logic {
    rmc_depth_8bpp,
    rmc_depth_16bpp
  } rmc_depth_t;
  typedef enum logic {
    rmc_width_512,
    rmc_width_1024
  } rmc_width_t;
endpackage

`default_nettype wire

// ===== rtl/rmc_addr_map.sv
// forms the graphics memory byte address from pixel coordinates
// assumes coordinates come from logic on the same clock
`include "rmc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module rmc_addr_map
  import rmc_pkg::*;
#(
  parameter int X_LOW_W = `RMC_X_LOW_W,
  parameter int Y_LOW_W = `RMC_Y_LOW_W
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // mode
  input wire logic memory_width_select,
  input wire logic pixel_depth_select,
  // coordinates
  input wire logic coord_valid,
  input wire logic [`RMC_X_W-1:0] pixel_x,
  input wire logic [`RMC_Y_W-1:0] pixel_y,
  // address
  output logic addr_valid,
  output rmc_byte_addr_t byte_addr
);

  logic next_addr_valid;
  rmc_byte_addr_t next_byte_addr;
  logic [3:0] x_bits;
  logic [31:0] x_full;
  logic [31:0] y_full;
  logic [31:0] x_low;
  logic [31:0] x_high;
  logic [31:0] y_low;
  logic [31:0] y_high;
  logic [31:0] tiled;

  always_comb begin
    x_bits = memory_width_select ? `RMC_X_BITS_1024 : `RMC_X_BITS_512;
    x_full = 32'(pixel_x) & ((32'h1 << x_bits) - 32'h1);
    y_full = 32'(pixel_y);
    x_low = x_full & ((32'h1 << X_LOW_W) - 32'h1);
    x_high = x_full >> X_LOW_W;
    y_low = y_full & ((32'h1 << Y_LOW_W) - 32'h1);
    y_high = y_full >> Y_LOW_W;
    // upper y, upper x, lower y, lower x
    tiled = (y_high << (32'(x_bits) + Y_LOW_W)) | (x_high << (X_LOW_W + Y_LOW_W)) | (y_low << X_LOW_W) | x_low;
    if (pixel_depth_select) begin
      tiled = tiled << 1;
    end
    next_byte_addr = coord_valid ? tiled[`RMC_BYTE_ADDR_W-1:0] : byte_addr;
    next_addr_valid = coord_valid;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_valid <= 1'b0;
      byte_addr <= '0;
    end else begin
      addr_valid <= next_addr_valid;
      byte_addr <= next_byte_addr;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/rmc_top.sv
// rendering mode register with apb access and memory address forming
// assumes an apb master on pclk; coordinates from same-clock drawing logic
//
// The implementer's own choices: the APB slave port and the register offsets.
`include "rmc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module rmc_top
  import rmc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RMC_APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mode outputs
  output logic memory_width_select,
  output logic pixel_depth_select,
  // pixel coordinates and address
  input wire logic coord_valid,
  input wire logic [`RMC_X_W-1:0] pixel_x,
  input wire logic [`RMC_Y_W-1:0] pixel_y,
  output logic addr_valid,
  output rmc_byte_addr_t byte_addr
);

  // ==========================================
  // apb decode
  logic hit;
  logic wr_take;
  logic next_memory_width_select;
  logic next_pixel_depth_select;
  logic [31:0] next_prdata;
  rmc_reg_t read_view;

  always_comb begin
    hit = 1'b0;
    if (paddr == `RMC_RENDERING_MODE_OFFSET) begin
      hit = 1'b1;
    end
  end

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign wr_take = psel && penable && pwrite && hit;

  // ==========================================
  // rendering mode register
  always_comb begin
    next_memory_width_select = memory_width_select;
    next_pixel_depth_select = pixel_depth_select;
    if (wr_take) begin
      next_memory_width_select = pwdata[`RMC_MEMORY_WIDTH_BIT];
      next_pixel_depth_select = pwdata[`RMC_PIXEL_DEPTH_BIT];
    end
  end

  // no reset term, values survive reset
  always_ff @(posedge pclk) begin
    memory_width_select <= next_memory_width_select;
    pixel_depth_select <= next_pixel_depth_select;
  end

  // ==========================================
  // read data, loaded in the setup cycle
  always_comb begin
    read_view = '0;
    read_view[`RMC_MEMORY_WIDTH_BIT] = memory_width_select;
    read_view[`RMC_PIXEL_DEPTH_BIT] = pixel_depth_select;
    next_prdata = prdata;
    if (psel && !penable) begin
      next_prdata = (hit && !pwrite) ? 32'(read_view) : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ==========================================
  // address forming
  // a mode change mid-draw alters the split at once
  rmc_addr_map u_addr_map (
    .pclk(pclk),
    .presetn(presetn),
    .memory_width_select(memory_width_select),
    .pixel_depth_select(pixel_depth_select),
    .coord_valid(coord_valid),
    .pixel_x(pixel_x),
    .pixel_y(pixel_y),
    .addr_valid(addr_valid),
    .byte_addr(byte_addr)
  );

endmodule

`default_nettype wire

// ===== tb/rmc_chk.sv
// checker on the rendering mode top ports
// assumes bind into rmc_top, single pclk domain
`include "rmc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module rmc_chk
  import rmc_pkg::*;
(
  // ports of rmc_top seen here
  input wire logic pclk, presetn, psel, penable, pwrite, pready, coord_valid, addr_valid,
  input wire logic memory_width_select, pixel_depth_select,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire rmc_byte_addr_t byte_addr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wr0;
    psel && penable && pwrite && paddr == 12'h000;
  endsequence
  a_read_back: assert property (psel && penable && !pwrite && paddr == 12'h000 |->
    prdata == {25'h0, memory_width_select, 5'h0, pixel_depth_select}) else $error("read mismatch");
  a_width_write: assert property (wr0 |=> memory_width_select == $past(pwdata[6])) else $error("width bit");
  a_depth_write: assert property (wr0 |=> pixel_depth_select == $past(pwdata[0])) else $error("depth bit");
  a_addr_follows: assert property (coord_valid |=> addr_valid) else $error("no address");
  a_addr_alone: assert property (!coord_valid |=> !addr_valid) else $error("stray address");
  a_even_byte: assert property (addr_valid && $past(pixel_depth_select) |-> !byte_addr[0]) else $error("odd");
endmodule
bind rmc_top rmc_chk rmc_chk_i(
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pready(pready),
  .coord_valid(coord_valid),
  .addr_valid(addr_valid),
  .memory_width_select(memory_width_select),
  .pixel_depth_select(pixel_depth_select),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .byte_addr(byte_addr)
);
`default_nettype wire

// ===== tb/rmc_mem_model.sv
// graphics memory stand-in: latches each byte address it is sent
// assumes addresses arrive on pclk with addr_valid
`timescale 1ns/1ps
`default_nettype none
module rmc_mem_model
  import rmc_pkg::*;
(
  input wire logic pclk,
  input wire logic addr_valid,
  input wire rmc_byte_addr_t byte_addr,
  output rmc_byte_addr_t mem_addr
);
  always_ff @(posedge pclk) begin
    if (addr_valid) begin
      mem_addr <= byte_addr;
    end
  end
endmodule
`default_nettype wire

// ===== tb/rmc_top_tb_top.sv
// bench for rmc_top: apb master, coordinate source, reference address model
// assumes zero-wait apb and one-cycle address latency
`timescale 1ns/1ps
`default_nettype none
module rmc_top_tb_top
  import rmc_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, coord_valid = 0;
  logic pready, pslverr, mws, pds, addr_valid, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [9:0] pixel_x = 0;
  logic [12:0] pixel_y = 0;
  rmc_byte_addr_t byte_addr, mem_addr;
  int n_errors = 0, compares = 0, mw, pd, xb, x, y, e;
  int exp_q[$];
  rmc_top rmc_top_i(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .memory_width_select(mws), .pixel_depth_select(pds), .coord_valid(coord_valid), .pixel_x(pixel_x),
    .pixel_y(pixel_y), .addr_valid(addr_valid), .byte_addr(byte_addr));
  rmc_mem_model rmc_mem_model_i(.pclk(pclk), .addr_valid(addr_valid), .byte_addr(byte_addr), .mem_addr(mem_addr));
  initial forever #20 pclk = ~pclk;
  task chk(input logic [31:0] v, input logic [31:0] x);
    compares++;
    if (v !== x) begin
      n_errors++;
      $display("[ERR] %0t %h %h", $time, v, x);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task wrap_up;
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    wrap_up;
  end
  initial begin
    void'($urandom(32'he2ae));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    for (int m = 0; m < 4; m++) begin
      mw = m / 2;
      pd = m % 2;
      apb(1, 12'h000, mw * 64 + pd);
      apb(0, 12'h000, 0);
      chk(rd, mw * 64 + pd);
      chk(32'({mws, pds}), mw * 2 + pd);
      repeat (6) begin
        x = $urandom;
        y = $urandom;
        @(posedge pclk);
        {coord_valid, pixel_x, pixel_y} <= {1'b1, x[9:0], y[12:0]};
        @(posedge pclk);
        coord_valid <= 0;
        @(posedge pclk);
        #1;
        xb = 9 + mw;
        x = x & ((1 << xb) - 1);
        y = y & 8191;
        e = ((y >> 2) << (xb + 2)) | ((x >> 3) << 5) | ((y & 3) << 3) | (x & 7);
        exp_q.push_back((e << pd) & 32'h7fffff);
        chk(mem_addr, exp_q.pop_front());
      end
    end
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 0);
    chk(rd, 32'h41);
    apb(0, 12'h004, 0);
    chk({rd[31:1], er}, 32'h1);
    wrap_up;
  end
endmodule
`default_nettype wire
